// file: hdl/schd_handler.sv
/*
 * Subcommand data handler: decodes subcommand codes written over Wishbone,
 * stages their data in a twelve-byte transfer buffer and applies writes.
 * Assumes a classic Wishbone master and charge/time inputs from the
 * coulomb counter that are synchronous to CLK.
 */
`timescale 1ns/1ps
`include "schd_defs.svh"
module schd_handler
	import schd_pkg::*;
#(
	parameter logic [15:0] PRODUCT_ID     = `SCHD_PRODUCT_ID,
	parameter logic [15:0] FIRMWARE_REV   = `SCHD_FIRMWARE_REV,
	parameter int unsigned BUILD_NUMBER   = `SCHD_BUILD_NUMBER,
	parameter logic [15:0] SILICON_REV    = `SCHD_SILICON_REV,
	parameter int unsigned KEY_WINDOW_CYC = `SCHD_KEY_WINDOW_CYC
) (
	input  wire logic        CLK,
	input  wire logic        RESETN,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [7:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	input  wire logic [47:0] CHARGE_ACC,
	input  wire logic [31:0] ACC_TIME,
	output logic      [7:0]  BALANCING_CELL_MASK,
	output logic      [15:0] REGULATOR_WAKE_TIMER,
	output logic      [7:0]  FAULT_RECOVERY_PERMIT,
	output logic             UNLOCKED_SECURITY_MODE
);
	localparam int NB = `SCHD_BUF_BYTES;

	// Build number as four BCD digits
	function automatic logic [15:0] to_bcd(input int unsigned v);
		logic [15:0] r;
		r = {4'(v / 1000 % 10), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
		return r;
	endfunction : to_bcd

	localparam logic [15:0] BUILD_BCD = to_bcd(BUILD_NUMBER);

	logic        bus_req;
	logic        ack_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic        wr_cmd;
	logic        wr_stat;
	logic        rd_go;
	logic        wr_go;
	schd_code_t  cmd_q;
	schd_code_t  new_code;
	schd_byte_t  buf_q [0:NB-1];
	schd_byte_t  snap_d [0:NB-1];
	logic [7:0]  bal_q;
	logic [15:0] timer_q;
	logic [7:0]  recov_q;
	logic        unlocked;
	logic        armed;
	logic        wr_permit;
	logic [47:0] charge_s;

	assign bus_req  = WB_CYC_I & WB_STB_I & ~ack_q;
	assign wr_cmd   = bus_req & WB_WE_I & (WB_ADR_I == `SCHD_ADDR_CMD) & WB_SEL_I[0] & WB_SEL_I[1];
	assign wr_stat  = bus_req & WB_WE_I & (WB_ADR_I == `SCHD_ADDR_STATUS) & WB_SEL_I[0];
	assign new_code = WB_DAT_I[15:0];
	assign wr_go    = wr_cmd & WB_SEL_I[2] & WB_DAT_I[`SCHD_CMD_EXEC_BIT];
	assign rd_go    = wr_cmd & ~wr_go;
	assign charge_s = CHARGE_ACC;

	// Wishbone answer one cycle after the request edge
	always_ff @(posedge CLK) begin
		if (!RESETN)
			ack_q <= 1'b0;
		else
			ack_q <= bus_req;
	end

	always_comb begin
		rdata_d = 32'h00000000;
		unique case (WB_ADR_I)
			`SCHD_ADDR_CMD:    rdata_d = {16'h0000, cmd_q};
			`SCHD_ADDR_DATA0:  rdata_d = {buf_q[3], buf_q[2], buf_q[1], buf_q[0]};
			`SCHD_ADDR_DATA1:  rdata_d = {buf_q[7], buf_q[6], buf_q[5], buf_q[4]};
			`SCHD_ADDR_DATA2:  rdata_d = {buf_q[11], buf_q[10], buf_q[9], buf_q[8]};
			`SCHD_ADDR_STATUS: begin
				rdata_d[`SCHD_STAT_UNLOCK_BIT] = unlocked;
				rdata_d[`SCHD_STAT_ARMED_BIT]  = armed;
			end
			default:           rdata_d = 32'h00000000;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (!RESETN)
			rdata_q <= 32'h00000000;
		else if (bus_req && !WB_WE_I)
			rdata_q <= rdata_d;
	end

	assign WB_ACK_O = ack_q;
	assign WB_DAT_O = rdata_q;

	always_ff @(posedge CLK) begin
		if (!RESETN)
			cmd_q <= 16'h0000;
		else if (wr_cmd)
			cmd_q <= new_code;
	end

	// Snapshot of the block that a read subcommand returns
	always_comb begin
		for (int i = 0; i < NB; i++)
			snap_d[i] = 8'h00;
		unique case (new_code)
			`SCHD_CODE_IDENT: begin
				snap_d[0] = PRODUCT_ID[7:0];
				snap_d[1] = PRODUCT_ID[15:8];
			end
			`SCHD_CODE_FWVER: begin
				snap_d[0] = PRODUCT_ID[15:8];
				snap_d[1] = PRODUCT_ID[7:0];
				snap_d[2] = FIRMWARE_REV[15:8];
				snap_d[3] = FIRMWARE_REV[7:0];
				snap_d[4] = BUILD_BCD[15:8];
				snap_d[5] = BUILD_BCD[7:0];
			end
			`SCHD_CODE_HWVER: begin
				snap_d[0] = SILICON_REV[7:0];
				snap_d[1] = SILICON_REV[15:8];
			end
			`SCHD_CODE_CHARGE: begin
				snap_d[0] = charge_s[7:0];
				snap_d[1] = charge_s[15:8];
				snap_d[2] = charge_s[23:16];
				snap_d[3] = charge_s[31:24];
				snap_d[4] = charge_s[39:32];
				snap_d[5] = charge_s[47:40];
				snap_d[6] = {8{charge_s[47]}};
				snap_d[7] = {8{charge_s[47]}};
				snap_d[8]  = ACC_TIME[7:0];
				snap_d[9]  = ACC_TIME[15:8];
				snap_d[10] = ACC_TIME[23:16];
				snap_d[11] = ACC_TIME[31:24];
			end
			`SCHD_CODE_BAL:    snap_d[0] = bal_q;
			`SCHD_CODE_TIMER: begin
				snap_d[0] = timer_q[7:0];
				snap_d[1] = timer_q[15:8];
			end
			`SCHD_CODE_RECOV:  snap_d[0] = recov_q;
			default:           snap_d[0] = 8'h00;
		endcase
	end

	// Transfer buffer: filled by a read subcommand or by data word writes
	for (genvar gi = 0; gi < NB; gi++) begin : g_buf
		localparam logic [7:0] WORD_ADR = 8'(`SCHD_ADDR_DATA0 + 4 * (gi / 4));

		always_ff @(posedge CLK) begin
			if (!RESETN)
				buf_q[gi] <= 8'h00;
			else if (rd_go)
				buf_q[gi] <= snap_d[gi];
			else if (bus_req && WB_WE_I && WB_ADR_I == WORD_ADR && WB_SEL_I[gi % 4])
				buf_q[gi] <= WB_DAT_I[8 * (gi % 4) +: 8];
		end
	end

	assign wr_permit = wr_go & unlocked;

	always_ff @(posedge CLK) begin
		if (!RESETN)
			bal_q <= `SCHD_BAL_RST;
		else if (wr_permit && new_code == `SCHD_CODE_BAL)
			bal_q <= buf_q[0];
	end

	always_ff @(posedge CLK) begin
		if (!RESETN)
			timer_q <= `SCHD_TIMER_RST;
		else if (wr_permit && new_code == `SCHD_CODE_TIMER)
			timer_q <= {buf_q[1], buf_q[0]};
	end

	always_ff @(posedge CLK) begin
		if (!RESETN)
			recov_q <= `SCHD_RECOV_RST;
		else if (wr_permit && new_code == `SCHD_CODE_RECOV)
			recov_q <= buf_q[0];
	end

	assign BALANCING_CELL_MASK    = bal_q;
	assign REGULATOR_WAKE_TIMER   = timer_q;
	assign FAULT_RECOVERY_PERMIT  = recov_q;
	assign UNLOCKED_SECURITY_MODE = unlocked;

	schd_unlock #(
		.KEY_WINDOW_CYC (KEY_WINDOW_CYC)
	) u_unlock (
		.clk        (CLK),
		.rst_n      (RESETN),
		.cmd_strobe (wr_cmd),
		.cmd_code   (new_code),
		.key_load   (wr_go && new_code == `SCHD_CODE_KEYS),
		.key_word   ({buf_q[3], buf_q[2], buf_q[1], buf_q[0]}),
		.seal_req   (wr_stat && !WB_DAT_I[`SCHD_STAT_UNLOCK_BIT]),
		.unlocked   (unlocked),
		.armed      (armed)
	);

	chk_ident_order: assert property (@(posedge CLK) disable iff (!RESETN)
		(rd_go && new_code == `SCHD_CODE_IDENT) |=>
		(buf_q[0] == PRODUCT_ID[7:0] && buf_q[1] == PRODUCT_ID[15:8] && buf_q[2] == 8'h00))
		else $error("product word not little endian");
	chk_fw_block: assert property (@(posedge CLK) disable iff (!RESETN)
		(rd_go && new_code == `SCHD_CODE_FWVER) |=> (buf_q[6] == 8'h00 && buf_q[7] == 8'h00))
		else $error("firmware block longer than six bytes");
	chk_fw_word_order: assert property (@(posedge CLK) disable iff (!RESETN)
		(rd_go && new_code == `SCHD_CODE_FWVER) |=>
		({buf_q[0], buf_q[1]} == PRODUCT_ID && {buf_q[2], buf_q[3]} == FIRMWARE_REV))
		else $error("firmware block words not big endian");
	chk_build_bcd: assert property (@(posedge CLK) disable iff (!RESETN)
		(rd_go && new_code == `SCHD_CODE_FWVER) |=>
		(buf_q[5][3:0] == 4'(BUILD_NUMBER % 10) && buf_q[4][7:4] == 4'(BUILD_NUMBER / 1000 % 10)))
		else $error("build number not BCD");
	chk_hw_word: assert property (@(posedge CLK) disable iff (!RESETN)
		(rd_go && new_code == `SCHD_CODE_HWVER) |=> ({buf_q[1], buf_q[0]} == SILICON_REV))
		else $error("hardware revision wrong");
	chk_charge_low: assert property (@(posedge CLK) disable iff (!RESETN)
		(rd_go && new_code == `SCHD_CODE_CHARGE) |=>
		({buf_q[3], buf_q[2], buf_q[1], buf_q[0]} == $past(CHARGE_ACC[31:0])))
		else $error("charge low word wrong");
	chk_charge_sign: assert property (@(posedge CLK) disable iff (!RESETN)
		(rd_go && new_code == `SCHD_CODE_CHARGE) |=>
		($signed({buf_q[7], buf_q[6], buf_q[5], buf_q[4]}) == $signed($past(CHARGE_ACC[47:32]))))
		else $error("charge high word not sign extended");
	chk_time_count: assert property (@(posedge CLK) disable iff (!RESETN)
		(rd_go && new_code == `SCHD_CODE_CHARGE) |=>
		({buf_q[11], buf_q[10], buf_q[9], buf_q[8]} == $past(ACC_TIME)))
		else $error("time count wrong");
	chk_bal_readback: assert property (@(posedge CLK) disable iff (!RESETN)
		(rd_go && new_code == `SCHD_CODE_BAL) |=> (buf_q[0] == BALANCING_CELL_MASK))
		else $error("balancing readback differs");
	chk_bal_write: assert property (@(posedge CLK) disable iff (!RESETN)
		(wr_go && unlocked && new_code == `SCHD_CODE_BAL) |=>
		(BALANCING_CELL_MASK == $past(buf_q[0])))
		else $error("balancing mask not applied");
	chk_bal_stop: assert property (@(posedge CLK) disable iff (!RESETN)
		(wr_go && unlocked && new_code == `SCHD_CODE_BAL && buf_q[0] == 8'h00) |=>
		(BALANCING_CELL_MASK == 8'h00) [*2])
		else $error("zero mask did not stop balancing");
	chk_timer_write: assert property (@(posedge CLK) disable iff (!RESETN)
		(wr_go && unlocked && new_code == `SCHD_CODE_TIMER) |=>
		(REGULATOR_WAKE_TIMER == {$past(buf_q[1]), $past(buf_q[0])}))
		else $error("wake timer not written");
	chk_recov_write: assert property (@(posedge CLK) disable iff (!RESETN)
		(wr_go && unlocked && new_code == `SCHD_CODE_RECOV) |=>
		(FAULT_RECOVERY_PERMIT == $past(buf_q[0])))
		else $error("recovery permit not written");
	chk_sealed_ignore: assert property (@(posedge CLK) disable iff (!RESETN)
		(wr_go && !unlocked) |=> ($stable(BALANCING_CELL_MASK) && $stable(REGULATOR_WAKE_TIMER)
		&& $stable(FAULT_RECOVERY_PERMIT)))
		else $error("sealed write changed state");
	cov_charge_read: cover property (@(posedge CLK) disable iff (!RESETN)
		rd_go && new_code == `SCHD_CODE_CHARGE);
	cov_bal_write: cover property (@(posedge CLK) disable iff (!RESETN)
		wr_permit && new_code == `SCHD_CODE_BAL);
	cov_sealed_write: cover property (@(posedge CLK) disable iff (!RESETN)
		wr_go && !unlocked);
	cov_key_replace: cover property (@(posedge CLK) disable iff (!RESETN)
		wr_go && unlocked && new_code == `SCHD_CODE_KEYS);

	// Bus protocol, transfer buffer, seal and control side-effect checks
	chk_ack_answer: assert property (@(posedge CLK) disable iff (!RESETN)
		bus_req |=> WB_ACK_O)
		else $error("request not acknowledged");
	chk_ack_single: assert property (@(posedge CLK) disable iff (!RESETN)
		WB_ACK_O |=> !WB_ACK_O)
		else $error("acknowledge longer than one cycle");
	chk_ack_idle: assert property (@(posedge CLK) disable iff (!RESETN)
		!(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O)
		else $error("acknowledge without request");
	chk_rdata_hold: assert property (@(posedge CLK) disable iff (!RESETN)
		!(bus_req && !WB_WE_I) |=> $stable(WB_DAT_O))
		else $error("read data changed without a read");
	chk_status_read: assert property (@(posedge CLK) disable iff (!RESETN)
		(bus_req && !WB_WE_I && WB_ADR_I == `SCHD_ADDR_STATUS) |=>
		(WB_DAT_O == {30'h0, $past(armed), $past(unlocked)}))
		else $error("status word wrong");
	chk_unmapped_read: assert property (@(posedge CLK) disable iff (!RESETN)
		(bus_req && !WB_WE_I && WB_ADR_I > `SCHD_ADDR_STATUS) |=>
		(WB_DAT_O == 32'h00000000))
		else $error("unmapped read not zero");
	chk_cmd_capture: assert property (@(posedge CLK) disable iff (!RESETN)
		wr_cmd |=> (cmd_q == $past(new_code)))
		else $error("subcommand code not captured");
	chk_seal_write: assert property (@(posedge CLK) disable iff (!RESETN)
		(wr_stat && !WB_DAT_I[`SCHD_STAT_UNLOCK_BIT]) |=>
		!UNLOCKED_SECURITY_MODE)
		else $error("seal request left block unlocked");
	chk_read_no_side: assert property (@(posedge CLK) disable iff (!RESETN)
		rd_go |=> ($stable(BALANCING_CELL_MASK) && $stable(REGULATOR_WAKE_TIMER)
		&& $stable(FAULT_RECOVERY_PERMIT)))
		else $error("read subcommand changed a control");
	chk_exec_keeps_buf: assert property (@(posedge CLK) disable iff (!RESETN)
		wr_go |=> ($stable(buf_q[0]) && $stable(buf_q[11])))
		else $error("execute write altered the buffer");
	chk_buf_lane: assert property (@(posedge CLK) disable iff (!RESETN)
		(bus_req && WB_WE_I && WB_ADR_I == `SCHD_ADDR_DATA0 && WB_SEL_I[0]) |=>
		(buf_q[0] == $past(WB_DAT_I[7:0])))
		else $error("buffer byte lane not written");
	chk_hw_len: assert property (@(posedge CLK) disable iff (!RESETN)
		(rd_go && new_code == `SCHD_CODE_HWVER) |=>
		(buf_q[2] == 8'h00 && buf_q[3] == 8'h00))
		else $error("hardware block longer than two bytes");
	chk_timer_read: assert property (@(posedge CLK) disable iff (!RESETN)
		(rd_go && new_code == `SCHD_CODE_TIMER) |=>
		({buf_q[1], buf_q[0]} == REGULATOR_WAKE_TIMER))
		else $error("wake timer readback differs");
	chk_recov_read: assert property (@(posedge CLK) disable iff (!RESETN)
		(rd_go && new_code == `SCHD_CODE_RECOV) |=>
		(buf_q[0] == FAULT_RECOVERY_PERMIT && buf_q[1] == 8'h00))
		else $error("recovery permit readback differs");
endmodule : schd_handler

// file: hdl/schd_defs.svh
/*
 * Constants of the subcommand data handler: register offsets, field
 * positions, subcommand codes, reset values and timing counts.
 * Assumes a 200 MHz core clock and a 32-bit classic Wishbone bus.
 */
`ifndef SCHD_DEFS_SVH
`define SCHD_DEFS_SVH

`define SCHD_ADDR_CMD        8'h00
`define SCHD_ADDR_DATA0      8'h04
`define SCHD_ADDR_DATA1      8'h08
`define SCHD_ADDR_DATA2      8'h0C
`define SCHD_ADDR_STATUS     8'h10

`define SCHD_CMD_EXEC_BIT    16
`define SCHD_STAT_UNLOCK_BIT 0
`define SCHD_STAT_ARMED_BIT  1
`define SCHD_BUF_BYTES       12

`define SCHD_CODE_IDENT      16'h0001
`define SCHD_CODE_FWVER      16'h0002
`define SCHD_CODE_HWVER      16'h0003
`define SCHD_CODE_CHARGE     16'h0004
`define SCHD_CODE_KEYS       16'h0035
`define SCHD_CODE_BAL        16'h0083
`define SCHD_CODE_TIMER      16'h0094
`define SCHD_CODE_RECOV      16'h009B

`define SCHD_BAL_RST         8'h00
`define SCHD_TIMER_RST       16'h0000
`define SCHD_RECOV_RST       8'h00
`define SCHD_KEY1_RST        16'h1A2B
`define SCHD_KEY2_RST        16'h3C4D

`define SCHD_PRODUCT_ID      16'h5A5A
`define SCHD_FIRMWARE_REV    16'h0100
`define SCHD_BUILD_NUMBER    1
`define SCHD_SILICON_REV     16'h0001

`define SCHD_CLK_HZ          200000000
`define SCHD_KEY_WINDOW_S    5
`define SCHD_KEY_WINDOW_CYC  (`SCHD_KEY_WINDOW_S * `SCHD_CLK_HZ)

`endif

// file: hdl/schd_pkg.sv
/*
 * Types shared by the subcommand data handler modules.
 * Assumes schd_defs.svh supplies the numeric constants.
 */
package schd_pkg;
	typedef logic [7:0]  schd_byte_t;
	typedef logic [15:0] schd_code_t;

	typedef enum logic [1:0] {
		SCHD_SEALED = 2'b00,
		SCHD_ARMED  = 2'b01,
		SCHD_OPEN   = 2'b10
	} schd_mode_e;
endpackage : schd_pkg

// file: hdl/schd_unlock.sv
/*
 * Security mode keeper: sealed, key word one seen, or unlocked.
 * Assumes cmd_strobe pulses once for every subcommand code written.
 */
`timescale 1ns/1ps
`include "schd_defs.svh"
module schd_unlock
	import schd_pkg::*;
#(
	parameter int unsigned KEY_WINDOW_CYC = `SCHD_KEY_WINDOW_CYC
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        cmd_strobe,
	input  wire schd_code_t  cmd_code,
	input  wire logic        key_load,
	input  wire logic [31:0] key_word,
	input  wire logic        seal_req,
	output logic             unlocked,
	output logic             armed
);
	schd_mode_e  mode_q;
	logic [31:0] wait_q;
	schd_code_t  key1_q;
	schd_code_t  key2_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mode_q <= SCHD_SEALED;
			wait_q <= 32'h00000000;
		end else begin
			unique case (mode_q)
				SCHD_SEALED: begin
					if (cmd_strobe && cmd_code == key1_q) begin
						mode_q <= SCHD_ARMED;
						wait_q <= 32'h00000000;
					end
				end
				SCHD_ARMED: begin
					if (cmd_strobe) begin
						if (cmd_code == key2_q)
							mode_q <= SCHD_OPEN;
						else if (cmd_code == key1_q)
							wait_q <= 32'h00000000;
						else
							mode_q <= SCHD_SEALED;
					end else if (wait_q == 32'(KEY_WINDOW_CYC - 1)) begin
						mode_q <= SCHD_SEALED;
					end else begin
						wait_q <= wait_q + 32'h00000001;
					end
				end
				SCHD_OPEN: begin
					if (seal_req)
						mode_q <= SCHD_SEALED;
				end
				default: mode_q <= SCHD_SEALED;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			key1_q <= `SCHD_KEY1_RST;
			key2_q <= `SCHD_KEY2_RST;
		end else if (key_load && mode_q == SCHD_OPEN) begin
			key1_q <= key_word[15:0];
			key2_q <= key_word[31:16];
		end
	end

	assign unlocked = (mode_q == SCHD_OPEN);
	assign armed    = (mode_q == SCHD_ARMED);

	chk_key_locked: assert property (@(posedge clk) disable iff (!rst_n)
		(key_load && mode_q != SCHD_OPEN) |=> ($stable(key1_q) && $stable(key2_q)))
		else $error("key block changed while sealed");
	chk_open_after_arm: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(unlocked) |-> ($past(mode_q) == SCHD_ARMED && $past(cmd_strobe)))
		else $error("unlocked without key word pair");
	chk_window_bound: assert property (@(posedge clk) disable iff (!rst_n)
		wait_q < 32'(KEY_WINDOW_CYC))
		else $error("key window counter overran");
	cov_unlock: cover property (@(posedge clk) disable iff (!rst_n) $rose(unlocked));
endmodule : schd_unlock

// file: verification/schd_host_model.sv
/*
 * Host model: a classic Wishbone master that issues subcommand accesses.
 * Assumes a slave that answers every request with a one-cycle ack.
 */
`timescale 1ns/1ps
`include "schd_defs.svh"
module schd_host_model
	import schd_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        ack,
	input  wire logic [31:0] dat_rd,
	output logic             cyc,
	output logic             stb,
	output logic             we,
	output logic      [7:0]  adr,
	output logic      [3:0]  sel,
	output logic      [31:0] dat_wr
);
	initial begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		dat_wr = 32'h0000_0000;
	end

	// Held until ack is sampled, then released
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] q);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		dat_wr <= d;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		q = dat_rd;
		cyc <= 1'b0;
		stb <= 1'b0;
		dat_wr <= ~d;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] q;
		bus(1'b1, a, d, s, q);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		bus(1'b0, a, 32'h0000_0000, 4'hF, q);
	endtask : rd

	task automatic send_keys(input schd_code_t k1, input schd_code_t k2);
		wr(`SCHD_ADDR_CMD, {16'h0000, k1}, 4'hF);
		wr(`SCHD_ADDR_CMD, {16'h0000, k2}, 4'hF);
	endtask : send_keys
endmodule : schd_host_model

// file: verification/schd_handler_tb_top.sv
/*
 * Testbench of the subcommand data handler: subcommand sequences with
 * expected values. Assumes the host model drives the Wishbone side.
 */
`timescale 1ns/1ps
`include "schd_defs.svh"
module schd_handler_tb_top import schd_pkg::*;;
	localparam int KWIN = 50;
	logic        clk;
	logic        rst_n;
	logic        cyc, stb, we, ack, unlocked;
	logic [7:0]  adr, mask, permit;
	logic [3:0]  sel;
	logic [31:0] dat_wr, dat_rd, acc_time, q;
	logic [47:0] charge;
	logic [15:0] timer;
	logic [47:0] chg_tab [2];
	int          fails, n_compared;

	schd_handler #(.PRODUCT_ID(16'hA512), .FIRMWARE_REV(16'h0302), .BUILD_NUMBER(47),
		.SILICON_REV(16'hC3B4), .KEY_WINDOW_CYC(KWIN)) dut_u (
		.CLK(clk), .RESETN(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_wr), .WB_DAT_O(dat_rd),
		.WB_ACK_O(ack), .CHARGE_ACC(charge), .ACC_TIME(acc_time),
		.BALANCING_CELL_MASK(mask), .REGULATOR_WAKE_TIMER(timer),
		.FAULT_RECOVERY_PERMIT(permit), .UNLOCKED_SECURITY_MODE(unlocked));

	schd_host_model host_u (.clk(clk), .ack(ack), .dat_rd(dat_rd), .cyc(cyc),
		.stb(stb), .we(we), .adr(adr), .sel(sel), .dat_wr(dat_wr));

	initial clk = 1'b0;
	always #2.5 clk = ~clk;

	task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("FAIL t=%0t bus got %h exp %h", $time, got, exp);
		end
	endtask : chk_bus

	task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("FAIL t=%0t pin got %h exp %h", $time, got, exp);
		end
	endtask : chk_pin

	task automatic query(input schd_code_t c, input logic [31:0] e0, e1, e2);
		host_u.wr(`SCHD_ADDR_CMD, {16'h0000, c}, 4'hF);
		host_u.rd(`SCHD_ADDR_DATA0, q);
		chk_bus(q, e0);
		host_u.rd(`SCHD_ADDR_DATA1, q);
		chk_bus(q, e1);
		host_u.rd(`SCHD_ADDR_DATA2, q);
		chk_bus(q, e2);
	endtask : query

	task automatic exec(input schd_code_t c, input logic [31:0] d, input logic [3:0] s);
		host_u.wr(`SCHD_ADDR_DATA0, d, s);
		host_u.wr(`SCHD_ADDR_CMD, {16'h0001, c}, 4'hF);
	endtask : exec

	task automatic end_sim;
		$display("Mismatches %0d, comparisons %0d", fails, n_compared);
		if (fails == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim

	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		end_sim;
	end

	initial begin
		fails = 0;
		n_compared = 0;
		rst_n = 1'b0;
		charge = 48'h0;
		acc_time = 32'h0;
		chg_tab[0] = 48'h8123_4567_89AB;
		chg_tab[1] = 48'h7FFF_0000_0001;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk_pin({mask, timer, permit}, 32'h0000_0000);
		chk_pin({31'h0, unlocked}, 32'h0);
		host_u.rd(`SCHD_ADDR_STATUS, q);
		chk_bus(q, 32'h0000_0000);
		host_u.rd(8'h14, q);
		chk_bus(q, 32'h0000_0000);
		query(`SCHD_CODE_IDENT, 32'h0000_A512, 32'h0, 32'h0);
		query(`SCHD_CODE_FWVER, 32'h0203_12A5, 32'h0000_4700, 32'h0);
		query(`SCHD_CODE_HWVER, 32'h0000_C3B4, 32'h0, 32'h0);
		for (int i = 0; i < 2; i++) begin
			@(posedge clk);
			charge <= chg_tab[i];
			acc_time <= 32'hF00D_0001 + i;
			query(`SCHD_CODE_CHARGE, chg_tab[i][31:0], {{16{chg_tab[i][47]}},
				chg_tab[i][47:32]}, 32'hF00D_0001 + i);
		end
		exec(`SCHD_CODE_BAL, 32'h0000_005F, 4'hF);
		exec(`SCHD_CODE_TIMER, 32'h0000_BEEF, 4'hF);
		exec(`SCHD_CODE_RECOV, 32'h0000_00C6, 4'hF);
		chk_pin({mask, timer, permit}, 32'h0000_0000);
		exec(`SCHD_CODE_KEYS, 32'h9999_8888, 4'hF);
		host_u.send_keys(`SCHD_KEY1_RST, `SCHD_KEY2_RST);
		chk_pin({31'h0, unlocked}, 32'h1);
		host_u.rd(`SCHD_ADDR_STATUS, q);
		chk_bus(q, 32'h0000_0001);
		exec(`SCHD_CODE_BAL, 32'h0000_005F, 4'hF);
		chk_pin({mask, timer, permit}, 32'h5F00_0000);
		query(`SCHD_CODE_BAL, 32'h0000_005F, 32'h0, 32'h0);
		exec(`SCHD_CODE_BAL, 32'h0000_0000, 4'hF);
		chk_pin({mask, timer, permit}, 32'h0000_0000);
		exec(`SCHD_CODE_TIMER, 32'h0000_BEEF, 4'hF);
		exec(`SCHD_CODE_RECOV, 32'h1122_33C6, 4'h1);
		chk_pin({mask, timer, permit}, 32'h00BE_EFC6);
		query(`SCHD_CODE_TIMER, 32'h0000_BEEF, 32'h0, 32'h0);
		query(`SCHD_CODE_RECOV, 32'h0000_00C6, 32'h0, 32'h0);
		// Replace keys, seal, retry both pairs
		exec(`SCHD_CODE_KEYS, 32'h5566_7788, 4'hF);
		host_u.wr(`SCHD_ADDR_STATUS, 32'h0, 4'h1);
		host_u.send_keys(`SCHD_KEY1_RST, `SCHD_KEY2_RST);
		chk_pin({31'h0, unlocked}, 32'h0);
		host_u.send_keys(16'h7788, 16'h5566);
		chk_pin({31'h0, unlocked}, 32'h1);
		host_u.wr(`SCHD_ADDR_STATUS, 32'h0, 4'h1);
		chk_pin({31'h0, unlocked}, 32'h0);
		host_u.wr(`SCHD_ADDR_CMD, 32'h0000_7788, 4'hF);
		host_u.wr(`SCHD_ADDR_CMD, {16'h0, `SCHD_CODE_IDENT}, 4'hF);
		host_u.wr(`SCHD_ADDR_CMD, 32'h0000_5566, 4'hF);
		chk_pin({31'h0, unlocked}, 32'h0);
		host_u.wr(`SCHD_ADDR_CMD, 32'h0000_7788, 4'hF);
		host_u.rd(`SCHD_ADDR_STATUS, q);
		chk_bus(q, 32'h0000_0002);
		repeat (KWIN + 10) @(posedge clk);
		host_u.wr(`SCHD_ADDR_CMD, 32'h0000_5566, 4'hF);
		chk_pin({31'h0, unlocked}, 32'h0);
		host_u.rd(`SCHD_ADDR_CMD, q);
		chk_bus(q, 32'h0000_5566);
		end_sim;
	end
endmodule : schd_handler_tb_top
